/* rtl/opt_pkg.sv */
package opt_pkg;

   // sizes of the timer block
   localparam int NUM_TMR = 4;
   localparam int RAW_W = 12;
   localparam int BASE_W = 16;
   localparam int ABS_W = 28;
   localparam int DIV_W = 29;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int CNT_W = 5;

   // clock and microsecond tick
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
   localparam logic [6:0] PRES_LAST = 7'(US_CYCLES - 1);

   // value limits and reset values
   localparam logic [RAW_W-1:0] RAW_MAX = 12'hFFF;
   localparam logic [RAW_W-1:0] RAW_ONE = 12'h001;
   localparam logic [RAW_W-1:0] DLY_RAW_RST = 12'h000;
   localparam logic [RAW_W-1:0] DUR_RAW_RST = 12'h001;
   localparam logic [BASE_W-1:0] BASE_RST = 16'h0001;
   localparam logic [BASE_W-1:0] BASE_MIN = 16'h0001;
   localparam logic [BASE_W-1:0] BASE_MAX = 16'hFFFF;
   localparam logic [ABS_W-1:0] ABS_MAX = 28'hFFFFFFF;
   localparam logic [1:0] TRIG_EXPO_START = 2'h1;

   // register word addresses
   localparam logic [ADDR_W-1:0] A_TIMER_SEL = 4'h0;
   localparam logic [ADDR_W-1:0] A_TRIG_SRC = 4'h1;
   localparam logic [ADDR_W-1:0] A_DLY_RAW = 4'h2;
   localparam logic [ADDR_W-1:0] A_DLY_ABS = 4'h3;
   localparam logic [ADDR_W-1:0] A_DLY_BASE = 4'h4;
   localparam logic [ADDR_W-1:0] A_DUR_RAW = 4'h5;
   localparam logic [ADDR_W-1:0] A_DUR_ABS = 4'h6;
   localparam logic [ADDR_W-1:0] A_DUR_BASE = 4'h7;
   localparam logic [ADDR_W-1:0] A_LINE_SEL = 4'h8;
   localparam logic [ADDR_W-1:0] A_LINE_INV = 4'h9;
   localparam logic [ADDR_W-1:0] A_USER_EN = 4'hA;
   localparam logic [ADDR_W-1:0] A_USER_VAL = 4'hB;
   localparam logic [ADDR_W-1:0] A_STATUS = 4'hC;

   typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_PULSE} opt_phase_t;

   typedef struct packed {
      opt_phase_t phase;
      logic [BASE_W-1:0] bcnt;
      logic [RAW_W-1:0] rcnt;
   } opt_tmr_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } opt_bus_req_t;

endpackage

/* rtl/opt_div.sv */
`timescale 1ns/1ns
`default_nettype none

module opt_div
   import opt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [DIV_W-1:0] dividend,
   input wire logic [BASE_W-1:0] divisor,
   output logic done,
   output logic [DIV_W-1:0] quotient
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [CNT_W-1:0] cnt;
      logic [BASE_W-1:0] rem;
      logic [BASE_W-1:0] den;
      logic [DIV_W-1:0] quo;
   } opt_div_state_t;

   opt_div_state_t s;
   opt_div_state_t next_s;

   // restoring division, one quotient bit per clock
   always_comb begin
      logic [BASE_W:0] t;
      t = '0;
      next_s = s;
      next_s.done = 1'b0;
      if (start) begin
         next_s.busy = 1'b1;
         next_s.cnt = '0;
         next_s.rem = '0;
         next_s.quo = dividend;
         next_s.den = divisor;
      end else if (s.busy) begin
         t = {s.rem, s.quo[DIV_W-1]};
         next_s.quo = {s.quo[DIV_W-2:0], 1'b0};
         if (t >= {1'b0, s.den}) begin
            t = t - {1'b0, s.den};
            next_s.quo[0] = 1'b1;
         end
         next_s.rem = t[BASE_W-1:0];
         if (s.cnt == CNT_W'(DIV_W - 1)) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 5'h01;
         end
      end
      if (rst) begin
         next_s = '0;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      s <= next_s;
   end

   assign done = s.done;
   assign quotient = s.quo;

endmodule

`default_nettype wire

/* rtl/opt_timers.sv */
`timescale 1ns/1ns
`default_nettype none

module opt_timers
   import opt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire opt_bus_req_t bus,
   input wire logic expo_start,
   output logic [DATA_W-1:0] rdata,
   output logic [NUM_TMR-1:0] out_line
);

   typedef struct packed {
      logic [1:0] tsel;
      logic [1:0] lsel;
      logic [NUM_TMR-1:0][1:0] trig;
      logic [NUM_TMR-1:0][RAW_W-1:0] dly;
      logic [NUM_TMR-1:0][RAW_W-1:0] dur;
      logic [BASE_W-1:0] dbase;
      logic [BASE_W-1:0] ubase;
      logic [NUM_TMR-1:0] inv;
      logic [NUM_TMR-1:0] user_en;
      logic [NUM_TMR-1:0] user_val;
      logic [6:0] pres;
      logic us_tick;
      logic [2:0] sync;
      opt_tmr_t [NUM_TMR-1:0] tmr;
      logic [NUM_TMR-1:0] line;
      logic [DATA_W-1:0] rdata;
      logic div_busy;
      logic div_kind;
      logic [1:0] div_idx;
   } opt_state_t;

   opt_state_t s;
   opt_state_t next_s;

   logic trig_edge;
   logic div_start;
   logic div_is_dur;
   logic [BASE_W-1:0] div_base;
   logic [ABS_W-1:0] abs_in;
   logic [DIV_W-1:0] div_num;
   logic div_done;
   logic [DIV_W-1:0] div_quo;
   logic [ABS_W-1:0] dly_abs_cur;
   logic [ABS_W-1:0] dur_abs_cur;

   // product of raw count and time base, the absolute time in microseconds
   function automatic logic [ABS_W-1:0] abs_of(input logic [RAW_W-1:0] raw,
                                                input logic [BASE_W-1:0] base);
      return ABS_W'(raw) * ABS_W'(base);
   endfunction

   // clamp a written or computed count into the raw range
   function automatic logic [RAW_W-1:0] sat_raw(input logic [DATA_W-1:0] v,
                                                 input logic min_one);
      if (v > DATA_W'(RAW_MAX)) begin
         return RAW_MAX;
      end else if (min_one && (v == '0)) begin
         return RAW_ONE;
      end
      return v[RAW_W-1:0];
   endfunction

   // clamp a written time base into its range, never below one microsecond
   function automatic logic [BASE_W-1:0] sat_base(input logic [DATA_W-1:0] v);
      if (v == '0) begin
         return BASE_MIN;
      end else if (v > DATA_W'(BASE_MAX)) begin
         return BASE_MAX;
      end
      return v[BASE_W-1:0];
   endfunction

   // last microsecond of one time-base unit
   function automatic logic unit_done(input logic [BASE_W-1:0] cnt,
                                      input logic [BASE_W-1:0] base);
      return cnt >= (base - BASE_MIN);
   endfunction

   // exposure start edge, seen on the second synchroniser stage
   assign trig_edge = s.sync[1] & ~s.sync[2];

   // absolute-to-raw conversion: add half a base so the quotient rounds
   assign div_is_dur = (bus.addr == A_DUR_ABS);
   assign div_start = bus.wr && !s.div_busy && ((bus.addr == A_DLY_ABS) || div_is_dur);
   assign div_base = div_is_dur ? s.ubase : s.dbase;
   assign abs_in = (bus.wdata > DATA_W'(ABS_MAX)) ? ABS_MAX : bus.wdata[ABS_W-1:0];
   assign div_num = DIV_W'(abs_in) + DIV_W'(div_base >> 1);

   // absolute readback of the selected timer
   assign dly_abs_cur = abs_of(s.dly[s.tsel], s.dbase);
   assign dur_abs_cur = abs_of(s.dur[s.tsel], s.ubase);

   opt_div u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_base),
      .done(div_done),
      .quotient(div_quo)
   );

   // whole next state: tick, sync, timers, lines, registers
   always_comb begin
      opt_tmr_t t;
      logic [NUM_TMR-1:0] act;
      logic src;
      t = '0;
      act = '0;
      src = 1'b0;
      next_s = s;
      next_s.rdata = '0;

      // microsecond prescaler
      next_s.us_tick = (s.pres == PRES_LAST);
      next_s.pres = next_s.us_tick ? '0 : s.pres + 7'h01;

      // two-stage synchroniser plus one stage for edge detection
      next_s.sync = {s.sync[1], s.sync[0], expo_start};

      // per-timer delay-then-pulse sequence
      for (int i = 0; i < NUM_TMR; i++) begin
         t = s.tmr[i];
         unique case (t.phase)
            PH_IDLE: begin
               if (trig_edge && (s.trig[i] == TRIG_EXPO_START)) begin
                  t.bcnt = '0;
                  t.rcnt = '0;
                  t.phase = (s.dly[i] == '0) ? PH_PULSE : PH_DELAY;
               end
            end
            PH_DELAY: begin
               if (s.us_tick) begin
                  if (unit_done(t.bcnt, s.dbase)) begin
                     t.bcnt = '0;
                     if ((t.rcnt + RAW_ONE) >= s.dly[i]) begin
                        t.rcnt = '0;
                        t.phase = PH_PULSE;
                     end else begin
                        t.rcnt = t.rcnt + RAW_ONE;
                     end
                  end else begin
                     t.bcnt = t.bcnt + BASE_MIN;
                  end
               end
            end
            PH_PULSE: begin
               if (s.us_tick) begin
                  if (unit_done(t.bcnt, s.ubase)) begin
                     t.bcnt = '0;
                     if ((t.rcnt + RAW_ONE) >= s.dur[i]) begin
                        t.rcnt = '0;
                        t.phase = PH_IDLE;
                     end else begin
                        t.rcnt = t.rcnt + RAW_ONE;
                     end
                  end else begin
                     t.bcnt = t.bcnt + BASE_MIN;
                  end
               end
            end
            default: begin
               t.phase = PH_IDLE;
            end
         endcase
         next_s.tmr[i] = t;
         act[i] = (s.tmr[i].phase != PH_IDLE);
         // timer i feeds line i, or the software value, then the inverter
         src = s.user_en[i] ? s.user_val[i] : (t.phase == PH_PULSE);
         next_s.line[i] = src ^ s.inv[i];
      end

      // register writes, per-timer fields go to the selected timer
      if (bus.wr) begin
         unique case (bus.addr)
            A_TIMER_SEL: next_s.tsel = bus.wdata[1:0];
            A_TRIG_SRC: begin
               if (bus.wdata[1:0] == TRIG_EXPO_START) begin
                  next_s.trig[s.tsel] = TRIG_EXPO_START;
               end
            end
            A_DLY_RAW: next_s.dly[s.tsel] = sat_raw(bus.wdata, 1'b0);
            A_DLY_BASE: next_s.dbase = sat_base(bus.wdata);
            A_DUR_RAW: next_s.dur[s.tsel] = sat_raw(bus.wdata, 1'b1);
            A_DUR_BASE: next_s.ubase = sat_base(bus.wdata);
            A_LINE_SEL: next_s.lsel = bus.wdata[1:0];
            A_LINE_INV: next_s.inv[s.lsel] = bus.wdata[0];
            A_USER_EN: next_s.user_en = bus.wdata[NUM_TMR-1:0];
            A_USER_VAL: next_s.user_val = bus.wdata[NUM_TMR-1:0];
            default: begin
            end
         endcase
      end

      // start of an absolute conversion remembers its target
      if (div_start) begin
         next_s.div_busy = 1'b1;
         next_s.div_kind = div_is_dur;
         next_s.div_idx = s.tsel;
      end

      // finished conversion stores the rounded raw count
      if (div_done) begin
         next_s.div_busy = 1'b0;
         if (s.div_kind) begin
            next_s.dur[s.div_idx] = sat_raw({3'h0, div_quo}, 1'b1);
         end else begin
            next_s.dly[s.div_idx] = sat_raw({3'h0, div_quo}, 1'b0);
         end
      end

      // register reads, data appear in the following cycle
      if (bus.rd) begin
         unique case (bus.addr)
            A_TIMER_SEL: next_s.rdata = {30'h0, s.tsel};
            A_TRIG_SRC: next_s.rdata = {30'h0, s.trig[s.tsel]};
            A_DLY_RAW: next_s.rdata = {20'h0, s.dly[s.tsel]};
            A_DLY_ABS: next_s.rdata = {4'h0, dly_abs_cur};
            A_DLY_BASE: next_s.rdata = {16'h0, s.dbase};
            A_DUR_RAW: next_s.rdata = {20'h0, s.dur[s.tsel]};
            A_DUR_ABS: next_s.rdata = {4'h0, dur_abs_cur};
            A_DUR_BASE: next_s.rdata = {16'h0, s.ubase};
            A_LINE_SEL: next_s.rdata = {30'h0, s.lsel};
            A_LINE_INV: next_s.rdata = {31'h0, s.inv[s.lsel]};
            A_USER_EN: next_s.rdata = {28'h0, s.user_en};
            A_USER_VAL: next_s.rdata = {28'h0, s.user_val};
            A_STATUS: next_s.rdata = {23'h0, s.div_busy, act, s.line};
            default: next_s.rdata = '0;
         endcase
      end

      // synchronous reset values
      if (rst) begin
         next_s = '0;
         next_s.dbase = BASE_RST;
         next_s.ubase = BASE_RST;
         for (int i = 0; i < NUM_TMR; i++) begin
            next_s.dly[i] = DLY_RAW_RST;
            next_s.dur[i] = DUR_RAW_RST;
            next_s.trig[i] = TRIG_EXPO_START;
            next_s.tmr[i].phase = PH_IDLE;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      s <= next_s;
   end

   // outputs straight from the state register
   assign rdata = s.rdata;
   assign out_line = s.line;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // timer 0 taking a trigger while idle
   sequence s_fire0;
      trig_edge && (s.tmr[0].phase == PH_IDLE) && (s.trig[0] == TRIG_EXPO_START);
   endsequence

   // timer 0 quiet on line 0 for two cycles with a steady inverter
   sequence s_idle0_held;
      ((s.tmr[0].phase == PH_IDLE) && !s.user_en[0]) [*2] ##0 $stable(s.inv[0]);
   endsequence

   // timer 0 pulsing for two cycles, no inversion, no software value
   sequence s_pulse0_held;
      ((s.tmr[0].phase == PH_PULSE) && !s.user_en[0] && !s.inv[0]) [*2];
   endsequence

   // software value held on line 0
   sequence s_user0_held;
      s.user_en[0] [*2] ##0 $stable(s.user_val[0]) ##0 $stable(s.inv[0]);
   endsequence

   // absolute delay write accepted by the converter
   sequence s_abs_write;
      bus.wr && (bus.addr == A_DLY_ABS) && !s.div_busy;
   endsequence

   a_start_delay: assert property ((s_fire0 and (s.dly[0] != '0)) |=>
      s.tmr[0].phase == PH_DELAY)
      else $error("timer 0 did not enter delay on trigger");

   a_zero_delay: assert property ((s_fire0 and (s.dly[0] == '0)) |=>
      s.tmr[0].phase == PH_PULSE)
      else $error("timer 0 with zero delay did not pulse at once");

   a_delay_exit: assert property ((s.tmr[0].phase == PH_DELAY) |=>
      (s.tmr[0].phase inside {PH_DELAY, PH_PULSE}))
      else $error("timer 0 left delay other than to pulse");

   a_retrig_ignored: assert property (trig_edge && (s.tmr[0].phase == PH_PULSE) |=>
      s.tmr[0].phase != PH_DELAY)
      else $error("timer 0 restarted while pulsing");

   a_line_idle: assert property (s_idle0_held |-> out_line[0] == s.inv[0])
      else $error("idle line 0 does not show its inverter setting");

   a_line_pulse: assert property (s_pulse0_held |-> out_line[0])
      else $error("line 0 low while timer 0 pulses");

   a_user_inverted: assert property (s_user0_held |->
      out_line[0] == (s.user_val[0] ^ s.inv[0]))
      else $error("software value on line 0 not passed through inverter");

   a_base_floor: assert property ((s.dbase >= BASE_MIN) && (s.ubase >= BASE_MIN))
      else $error("time base fell below one microsecond");

   a_dur_floor: assert property (s.dur[0] != '0)
      else $error("duration count of timer 0 is zero");

   a_abs_convert: assert property (s_abs_write |=> s.div_busy ##[1:40] !s.div_busy)
      else $error("absolute delay conversion did not finish in time");

   a_abs_readback: assert property (bus.rd && (bus.addr == A_DLY_ABS) |=>
      s.rdata == {4'h0, $past(dly_abs_cur)})
      else $error("absolute delay readback differs from raw times base");

endmodule

`default_nettype wire

/* bench/opt_ext_eq.sv */
`timescale 1ns/1ns
`default_nettype none

module opt_ext_eq
   import opt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic fire,
   input wire logic [NUM_TMR-1:0] out_line,
   output logic expo_start,
   output int t_rise [NUM_TMR],
   output int t_fall [NUM_TMR],
   output int n_rise [NUM_TMR]
);
   int t = 10000;
   logic expo_q = 1'b0;
   logic [NUM_TMR-1:0] last = '0;

   assign expo_start = expo_q;

   // exposure level, then a second exposure while the timers are still busy
   // line edges are timed in cycles from the fire request
   always @(posedge sys_clk) begin
      expo_q <= (t < 20) || (t >= 300 && t < 320);
      last <= out_line;
      if (fire) begin
         t <= 0;
         for (int i = 0; i < NUM_TMR; i++) begin
            n_rise[i] <= 0;
            t_rise[i] <= -1;
            t_fall[i] <= -1;
         end
      end else begin
         t <= t + 1;
         for (int i = 0; i < NUM_TMR; i++) begin
            if (out_line[i] && !last[i]) begin
               n_rise[i] <= n_rise[i] + 1;
               t_rise[i] <= t;
            end
            if (!out_line[i] && last[i]) begin
               t_fall[i] <= t;
            end
         end
      end
   end
endmodule

`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb
   import opt_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic fire = 1'b0;
   opt_bus_req_t bus = '0;
   logic expo_start;
   logic [DATA_W-1:0] rdata;
   logic [NUM_TMR-1:0] out_line;
   int t_rise [NUM_TMR];
   int t_fall [NUM_TMR];
   int n_rise [NUM_TMR];
   int n_mismatch = 0;
   int n_checks = 0;
   int m_dly [NUM_TMR];
   int m_dur [NUM_TMR];
   int m_db;
   int m_ub;

   opt_timers uut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .expo_start(expo_start),
      .rdata(rdata), .out_line(out_line));

   opt_ext_eq ext (.sys_clk(sys_clk), .fire(fire), .out_line(out_line),
      .expo_start(expo_start), .t_rise(t_rise), .t_fall(t_fall), .n_rise(n_rise));

   // 100 MHz clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe is taken
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] d;
      rd(a, d);
      chk_val(d, exp);
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
         n_mismatch++;
      end
   endtask

   // poll the conversion busy flag, bounded
   task automatic wait_idle();
      logic [DATA_W-1:0] s;
      for (int k = 0; k < 40; k++) begin
         rd(A_STATUS, s);
         if (s[8] === 1'b0) return;
      end
      n_mismatch++;
      wrap_up();
   endtask

   initial begin
      int de;
      int a;
      int ex;
      int uen;
      int uv;
      int minv;
      bit done;
      void'($urandom(32'hE588DA60));
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values and refused writes
      chk_reg(A_TRIG_SRC, 32'h1);
      chk_reg(A_DLY_RAW, 32'h0);
      chk_reg(A_DLY_BASE, 32'h1);
      chk_reg(A_DUR_RAW, 32'h1);
      chk_reg(A_DUR_BASE, 32'h1);
      chk_reg(A_STATUS, 32'h0);
      wr(4'hE, 32'h5A);
      chk_reg(4'hE, 32'h0);
      wr(A_TRIG_SRC, 32'h2);
      chk_reg(A_TRIG_SRC, 32'h1);
      // field limits
      wr(A_DLY_RAW, 32'h1000);
      chk_reg(A_DLY_RAW, 32'hFFF);
      wr(A_DUR_RAW, 32'h0);
      chk_reg(A_DUR_RAW, 32'h1);
      wr(A_DLY_BASE, 32'h0);
      chk_reg(A_DLY_BASE, 32'h1);
      wr(A_DUR_BASE, 32'h0);
      chk_reg(A_DUR_BASE, 32'h1);
      // shared bases, then per-timer counts
      m_db = 2;
      m_ub = 2;
      wr(A_DLY_BASE, 32'(m_db));
      wr(A_DUR_BASE, 32'(m_ub));
      chk_reg(A_DLY_BASE, 32'(m_db));
      chk_reg(A_DUR_BASE, 32'(m_ub));
      for (int i = 0; i < NUM_TMR; i++) begin
         m_dly[i] = (i == 0) ? 0 : $urandom_range(3, 1);
         m_dur[i] = $urandom_range(3, 2);
         wr(A_TIMER_SEL, 32'(i));
         wr(A_DLY_RAW, 32'(m_dly[i]));
         wr(A_DUR_RAW, 32'(m_dur[i]));
      end
      for (int i = 0; i < NUM_TMR; i++) begin
         wr(A_TIMER_SEL, 32'(i));
         chk_reg(A_DLY_RAW, 32'(m_dly[i]));
         chk_reg(A_DUR_RAW, 32'(m_dur[i]));
         chk_reg(A_DLY_ABS, 32'(m_dly[i] * m_db));
         chk_reg(A_DUR_ABS, 32'(m_dur[i] * m_ub));
      end
      // exposure fires all four timers; a second exposure comes mid-cycle
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      done = 1'b0;
      for (int k = 0; k < 2000 && !done; k++) begin
         @(posedge sys_clk);
         done = 1'b1;
         for (int i = 0; i < NUM_TMR; i++) done &= (t_fall[i] >= 0);
      end
      if (!done) begin
         n_mismatch++;
         wrap_up();
      end
      for (int i = 0; i < NUM_TMR; i++) begin
         de = m_dly[i] * m_db * US_CYCLES;
         chk_rng(t_rise[i], (de == 0) ? 2 : de - US_CYCLES, de + 8);
         ex = m_dur[i] * m_ub * US_CYCLES;
         // a zero-delay pulse starts off the tick, so its first unit may be short
         chk_rng(t_fall[i] - t_rise[i], (m_dly[i] == 0) ? ex - US_CYCLES : ex - 1, ex + 1);
         chk_rng(n_rise[i], 1, 1);
      end
      // absolute writes round to the nearest multiple of the base
      wr(A_TIMER_SEL, 32'h1);
      for (int k = 0; k < 3; k++) begin
         m_db = $urandom_range(5, 1);
         m_ub = $urandom_range(5, 1);
         wr(A_DLY_BASE, 32'(m_db));
         wr(A_DUR_BASE, 32'(m_ub));
         a = $urandom_range(300, 0);
         wr(A_DLY_ABS, 32'(a));
         wait_idle();
         ex = (a + m_db / 2) / m_db;
         chk_reg(A_DLY_RAW, 32'(ex));
         chk_reg(A_DLY_ABS, 32'(ex * m_db));
         a = (k == 0) ? 0 : $urandom_range(300, 0);
         wr(A_DUR_ABS, 32'(a));
         wait_idle();
         ex = (a + m_ub / 2) / m_ub;
         ex = (ex < 1) ? 1 : ex;
         chk_reg(A_DUR_RAW, 32'(ex));
         chk_reg(A_DUR_ABS, 32'(ex * m_ub));
      end
      // inverters on lines 1 and 2, then software-set values through them
      minv = 6;
      wr(A_LINE_SEL, 32'h1);
      wr(A_LINE_INV, 32'h1);
      wr(A_LINE_SEL, 32'h2);
      wr(A_LINE_INV, 32'h1);
      chk_reg(A_STATUS, 32'(minv));
      chk_val({28'h0, out_line}, 32'(minv));
      for (int k = 0; k < 6; k++) begin
         uen = $urandom_range(15, 0);
         uv = $urandom_range(15, 0);
         wr(A_USER_EN, 32'(uen));
         wr(A_USER_VAL, 32'(uv));
         repeat (2) @(posedge sys_clk);
         #1 chk_val({28'h0, out_line}, 32'((uen & uv) ^ minv));
      end
      wrap_up();
   end
endmodule

`default_nettype wire
